// file: hdl/lcr_map.svh
// Register map, field positions and reset values of the lane config block.
// Assumes inclusion by bare name from every file that needs the numbers.
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH
// ==================================================
// Register indices
`define LCR_IDX_PDOWN 8'h02
`define LCR_IDX_LANE0 8'h03
`define LCR_IDX_LANE3 8'h06
// ==================================================
// Reset values and fields
`define LCR_RST_PDOWN 8'h00
`define LCR_RST_LANE 8'h00
`define LCR_PD_LSB 4
`define LCR_ADDR_HI 3'h7
`define LCR_BIT_LAST 4'h7
`define LCR_BIT_ACK 4'h8
`define LCR_PIN_RST 17'h08003
`endif

// file: hdl/lcr_pkg.sv
// Types shared by the lane config block and its bus link.
// Assumes nothing of its surroundings.
package lcr_pkg;
  // ==================================================
  // Link phases
  typedef enum logic [2:0] {
    ph_idle  = 3'b000,
    ph_addr  = 3'b001,
    ph_index = 3'b010,
    ph_write = 3'b011,
    ph_read  = 3'b100
  } lcr_phase_type;
  typedef logic [7:0] lcr_byte_type;
endpackage : lcr_pkg

// file: hdl/lcr_link_if.sv
// Signals between the core clock domain and the serial clock link.
// Assumes ev fields stay stable from one ev_tgl flip to the next.
`timescale 1ns/1ps
interface lcr_link_if;
  // ==================================================
  // Link to core: byte events
  logic       ev_tgl;
  logic       ev_wr;
  logic [7:0] ev_idx;
  logic [7:0] ev_data;
  logic [7:0] ev_ptr;
  // ==================================================
  // Core to link: quasi-static levels
  logic [7:0] rd_data;
  logic [3:0] slave_id;
  logic       link_rst_n;
  modport link (output ev_tgl, ev_wr, ev_idx, ev_data, ev_ptr,
                input  rd_data, slave_id, link_rst_n);
  modport core (input  ev_tgl, ev_wr, ev_idx, ev_data, ev_ptr,
                output rd_data, slave_id, link_rst_n);
endinterface : lcr_link_if

// file: hdl/lcr_i2c_link.sv
// Serial bus slave on the bus clock: address, index, write and read bytes.
// Assumes link_rst_n from the core holds it idle outside frames.
`timescale 1ns/1ps
`include "lcr_map.svh"
module lcr_i2c_link
  import lcr_pkg::*;
(
  input  wire logic scl,
  input  wire logic arst_n,
  input  wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe,
  lcr_link_if.link  lnk
);
  // ==================================================
  // Frame state
  logic [3:0]    bit_cnt_ff;
  lcr_byte_type  sr_ff;
  lcr_byte_type  tx_sr_ff;
  lcr_phase_type phase_ff;
  logic          ack_ff;
  logic          oe_ff;
  lcr_byte_type  ptr_ff;
  lcr_byte_type  byte_in;
  lcr_byte_type  tx_cur;
  lcr_phase_type nxt_phase;
  logic          nxt_ack;
  logic          in_hit;
  logic          sr_hit;
  logic          ack_edge;
  logic          ev_fire;

  // Decode of the byte on the bus
  assign byte_in  = {sr_ff[6:0], sda_in};
  assign in_hit   = byte_in[7:1] == {`LCR_ADDR_HI, lnk.slave_id};
  assign sr_hit   = sr_ff[7:1] == {`LCR_ADDR_HI, lnk.slave_id};
  assign ack_edge = bit_cnt_ff == `LCR_BIT_ACK;
  assign nxt_ack  = (phase_ff == ph_addr) ? in_hit :
                    (phase_ff == ph_index) || (phase_ff == ph_write);
  assign ev_fire  = ack_edge && ((phase_ff == ph_index) ||
                    (phase_ff == ph_write) || (phase_ff == ph_read));
  assign tx_cur   = (bit_cnt_ff == 4'h0) ? lnk.rd_data : tx_sr_ff;
  assign sda_out  = 1'b0;
  assign sda_oe   = oe_ff;

  // Phase after the acknowledge clock
  always_comb begin
    case (phase_ff)
      ph_addr:  nxt_phase = sr_hit ? (sr_ff[0] ? ph_read : ph_index) : ph_idle;
      ph_index: nxt_phase = ph_write;
      ph_write: nxt_phase = ph_write;
      ph_read:  nxt_phase = sda_in ? ph_idle : ph_read;
      default:  nxt_phase = ph_idle;
    endcase
  end

  // Shift in on rising clock, count nine clocks per byte
  always_ff @(posedge scl or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      bit_cnt_ff <= 4'h0;
      sr_ff      <= 8'h00;
      phase_ff   <= ph_addr;
      ack_ff     <= 1'b0;
    end else if (ack_edge) begin
      bit_cnt_ff <= 4'h0;
      phase_ff   <= nxt_phase;
    end else begin
      sr_ff      <= byte_in;
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (bit_cnt_ff == `LCR_BIT_LAST) begin
        ack_ff <= nxt_ack;
      end
    end
  end

  // Byte events and register pointer, kept across frames
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff      <= 8'h00;
      lnk.ev_tgl  <= 1'b0;
      lnk.ev_wr   <= 1'b0;
      lnk.ev_idx  <= 8'h00;
      lnk.ev_data <= 8'h00;
    end else if (ev_fire) begin
      lnk.ev_tgl <= ~lnk.ev_tgl;
      lnk.ev_wr  <= phase_ff == ph_write;
      if (phase_ff == ph_index) begin
        ptr_ff <= sr_ff;
      end else begin
        ptr_ff <= ptr_ff + 8'h01;
      end
      if (phase_ff == ph_write) begin
        lnk.ev_idx  <= ptr_ff;
        lnk.ev_data <= sr_ff;
      end
    end
  end
  assign lnk.ev_ptr = ptr_ff;

  // Drive acknowledge and read bits on falling clock
  always_ff @(negedge scl or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      oe_ff    <= 1'b0;
      tx_sr_ff <= 8'h00;
    end else if (ack_edge) begin
      oe_ff <= ack_ff;
    end else if (phase_ff == ph_read) begin
      oe_ff    <= ~tx_cur[7];
      tx_sr_ff <= {tx_cur[6:0], 1'b0};
    end else begin
      oe_ff <= 1'b0;
    end
  end
endmodule : lcr_i2c_link

// file: hdl/lcr_top.sv
// Lane configuration core: pin filters, register bank, lane setting outputs.
// Assumes scl and sda come straight from pins and straps change rarely.
`timescale 1ns/1ps
`include "lcr_map.svh"
module lcr_top
  import lcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        reg_reset_n,
  input  wire logic        cable_detect_n,
  input  wire logic        cfg_source_sel,
  input  wire logic [3:0]  boost_level_sel,
  input  wire logic [1:0]  flat_gain_sel,
  input  wire logic [1:0]  output_level_sel,
  input  wire logic [3:0]  slave_id,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe,
  output wire logic [15:0] lane_boost,
  output wire logic [7:0]  lane_flat_gain,
  output wire logic [7:0]  lane_out_level,
  output wire logic [3:0]  lane_enable,
  output wire logic [3:0]  tx_hiz,
  output wire logic        rx_term_weak
);
  localparam int PW = 17;
  localparam int NL = 4;
  localparam logic [PW-1:0] PIN_RST = `LCR_PIN_RST;

  // ==================================================
  // Pin filters
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_flt;

  // Pins in a fixed order, reset levels match
  assign pin_raw = {reg_reset_n, cable_detect_n, cfg_source_sel,
                    boost_level_sel, flat_gain_sel, output_level_sel,
                    slave_id, scl, sda_in};

  // Three stages; a new level counts once stages two and three agree
  for (genvar g = 0; g < PW; g++) begin : g_pin
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic flt_ff;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        s1_ff  <= PIN_RST[g];
        s2_ff  <= PIN_RST[g];
        s3_ff  <= PIN_RST[g];
        flt_ff <= PIN_RST[g];
      end else begin
        s1_ff <= pin_raw[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          flt_ff <= s3_ff;
        end
      end
    end
    assign pin_flt[g] = flt_ff;
  end

  // ==================================================
  // Filtered pin levels
  logic       rr_n;
  logic       no_cable;
  logic       reg_mode;
  logic [3:0] st_boost;
  logic [1:0] st_gain;
  logic [1:0] st_level;
  logic [3:0] id_flt;
  logic       scl_f;
  logic       sda_f;

  // Unpack in the same order as packed
  assign rr_n     = pin_flt[16];
  assign no_cable = pin_flt[15];
  assign reg_mode = pin_flt[14];
  assign st_boost = pin_flt[13:10];
  assign st_gain  = pin_flt[9:8];
  assign st_level = pin_flt[7:6];
  assign id_flt   = pin_flt[5:2];
  assign scl_f    = pin_flt[1];
  assign sda_f    = pin_flt[0];

  // ==================================================
  // Frame detection
  logic sda_d_ff;
  logic in_frame_ff;
  logic link_rst_n_ff;
  logic start_det;
  logic stop_det;

  // Start is sda falling while scl high, stop is sda rising
  assign start_det = scl_f && sda_d_ff && !sda_f;
  assign stop_det  = scl_f && !sda_d_ff && sda_f;

  // Link held in reset between frames and pulsed on every start;
  // the release lands while scl stands high after a start, clear of scl edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_d_ff      <= 1'b1;
      in_frame_ff   <= 1'b0;
      link_rst_n_ff <= 1'b0;
    end else begin
      sda_d_ff      <= sda_f;
      in_frame_ff   <= start_det || (in_frame_ff && !stop_det);
      link_rst_n_ff <= in_frame_ff && !start_det && !stop_det;
    end
  end

  // ==================================================
  // Serial link on the bus clock
  lcr_link_if lnk ();

  lcr_i2c_link u_link (
    .scl     (scl),
    .arst_n  (arst_n),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .lnk     (lnk.link)
  );

  // Quasi-static levels toward the link
  assign lnk.link_rst_n = link_rst_n_ff;
  assign lnk.slave_id   = id_flt;

  // ==================================================
  // Event crossing from the bus clock
  logic ev_s1_ff;
  logic ev_s2_ff;
  logic ev_s3_ff;
  logic ev_hit;
  logic wr_go;

  // Toggle synchroniser; stage one feeds only stage two
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ev_s1_ff <= 1'b0;
      ev_s2_ff <= 1'b0;
      ev_s3_ff <= 1'b0;
    end else begin
      ev_s1_ff <= lnk.ev_tgl;
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
    end
  end

  // One pulse per byte event, write when flagged
  assign ev_hit = ev_s2_ff ^ ev_s3_ff;
  assign wr_go  = ev_hit && lnk.ev_wr;

  // ==================================================
  // Write event held in the core domain
  logic         wr_go_ff;
  lcr_byte_type wr_idx_ff;
  lcr_byte_type wr_data_ff;

  // Link fields settle long before the toggle is seen, so one capture on
  // the pulse gives the register bank a copy that no scl edge can move
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_go_ff   <= 1'b0;
      wr_idx_ff  <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_go_ff <= wr_go;
      if (wr_go) begin
        wr_idx_ff  <= lnk.ev_idx;
        wr_data_ff <= lnk.ev_data;
      end
    end
  end

  // ==================================================
  // Power-down register
  lcr_byte_type pd_ff;
  logic         pd_wr;

  // Reserved bytes 0 and 1 decode to nothing and are dropped
  assign pd_wr = wr_go_ff && (wr_idx_ff == `LCR_IDX_PDOWN);

  // Full byte stored; low nibble is plain storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pd_ff <= `LCR_RST_PDOWN;
    end else if (!rr_n) begin
      pd_ff <= `LCR_RST_PDOWN;
    end else if (pd_wr) begin
      pd_ff <= wr_data_ff;
    end
  end

  // ==================================================
  // Lane registers and lane outputs
  lcr_byte_type lane_cfg [NL];
  logic         pwr_dn_ff;

  // Global power-down from cable detect, any control mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_dn_ff <= 1'b1;
    end else begin
      pwr_dn_ff <= no_cable;
    end
  end
  assign rx_term_weak = pwr_dn_ff;

  for (genvar i = 0; i < NL; i++) begin : g_lane
    localparam lcr_byte_type LIDX = `LCR_IDX_LANE0 + 8'(i);
    lcr_byte_type cfg_ff;
    logic [3:0]   boost_ff;
    logic [1:0]   gain_ff;
    logic [1:0]   level_ff;
    logic         en_ff;
    logic         cfg_wr;
    logic [3:0]   nxt_boost;
    logic [1:0]   nxt_gain;
    logic [1:0]   nxt_level;
    logic         nxt_en;

    // Lane byte write decode
    assign cfg_wr = wr_go_ff && (wr_idx_ff == LIDX);

    // Lane byte storage
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cfg_ff <= `LCR_RST_LANE;
      end else if (!rr_n) begin
        cfg_ff <= `LCR_RST_LANE;
      end else if (cfg_wr) begin
        cfg_ff <= wr_data_ff;
      end
    end
    assign lane_cfg[i] = cfg_ff;

    // Source select: register fields or shared strap codes
    assign nxt_boost = reg_mode ? cfg_ff[7:4] : st_boost;
    assign nxt_gain  = reg_mode ? cfg_ff[3:2] : st_gain;
    assign nxt_level = reg_mode ? cfg_ff[1:0] : st_level;
    // Lane bit counts only in register mode; cable overrides all
    assign nxt_en    = !no_cable &&
                       !(reg_mode && pd_ff[`LCR_PD_LSB + i]);

    // Registered lane settings
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        boost_ff <= 4'h0;
        gain_ff  <= 2'h0;
        level_ff <= 2'h0;
        en_ff    <= 1'b0;
      end else begin
        boost_ff <= nxt_boost;
        gain_ff  <= nxt_gain;
        level_ff <= nxt_level;
        en_ff    <= nxt_en;
      end
    end

    // Lane slices of the packed outputs
    assign lane_boost[4*i +: 4]     = boost_ff;
    assign lane_flat_gain[2*i +: 2] = gain_ff;
    assign lane_out_level[2*i +: 2] = level_ff;
    assign lane_enable[i]           = en_ff;
    assign tx_hiz[i]                = !en_ff;
  end

  // ==================================================
  // Read data toward the link
  lcr_byte_type rd_ptr_ff;
  lcr_byte_type rd_data_ff;
  lcr_byte_type lane_off;
  logic         rd_pd;
  logic         rd_lane;
  lcr_byte_type rd_mux;

  // Pointer follows every byte event from the link
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_ff <= 8'h00;
    end else if (ev_hit) begin
      rd_ptr_ff <= lnk.ev_ptr;
    end
  end

  // Read select; reserved and unmapped bytes read zero
  assign lane_off = rd_ptr_ff - `LCR_IDX_LANE0;
  assign rd_pd    = rd_ptr_ff == `LCR_IDX_PDOWN;
  assign rd_lane  = (rd_ptr_ff >= `LCR_IDX_LANE0) &&
                    (rd_ptr_ff <= `LCR_IDX_LANE3);
  assign rd_mux   = rd_pd   ? pd_ff :
                    rd_lane ? lane_cfg[lane_off[1:0]] :
                    8'h00;

  // Registered read byte, refreshed every cycle; it moves only on a pointer
  // or register change, well before the scl fall that loads it into the link
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= rd_mux;
    end
  end
  assign lnk.rd_data = rd_data_ff;
endmodule : lcr_top

// file: bench/lcr_top_assertions.sv
// Concurrent checks on the ports of the lane configuration core.
// Assumes binding onto lcr_top; every check samples on the core clock.
`timescale 1ns/1ps
module lcr_chk (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        reg_reset_n,
  input wire logic        cable_detect_n,
  input wire logic        cfg_source_sel,
  input wire logic [3:0]  boost_level_sel,
  input wire logic [1:0]  flat_gain_sel,
  input wire logic [1:0]  output_level_sel,
  input wire logic [3:0]  slave_id,
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [15:0] lane_boost,
  input wire logic [7:0]  lane_flat_gain,
  input wire logic [7:0]  lane_out_level,
  input wire logic [3:0]  lane_enable,
  input wire logic [3:0]  tx_hiz,
  input wire logic        rx_term_weak
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ====
  // Steady pin windows, long enough for the pin filters
  sequence s_strap;
    (!cfg_source_sel && $stable({boost_level_sel, flat_gain_sel, output_level_sel})
      && $stable(cable_detect_n))[*8];
  endsequence
  sequence s_regrst;
    (cfg_source_sel && !reg_reset_n && !cable_detect_n)[*8];
  endsequence
  // ====
  // Lane power and settings
  property p_hiz; tx_hiz == ~lane_enable; endproperty
  a_hiz: assert property (p_hiz) else $error("tx_hiz not inverse of enable");
  property p_weak; rx_term_weak |-> lane_enable == 4'h0; endproperty
  a_weak: assert property (p_weak) else $error("lane on in power-down");
  property p_cable; cable_detect_n [*8] |-> rx_term_weak && tx_hiz == 4'hf; endproperty
  a_cable: assert property (p_cable) else $error("no power-down without cable");
  property p_present; (!cable_detect_n) [*8] |-> !rx_term_weak; endproperty
  a_present: assert property (p_present) else $error("weak term with cable");
  property p_strap_boost; s_strap |-> lane_boost == {4{boost_level_sel}}; endproperty
  a_strap_boost: assert property (p_strap_boost) else $error("strap boost");
  property p_strap_gain;
    s_strap |-> lane_flat_gain == {4{flat_gain_sel}} && lane_out_level == {4{output_level_sel}};
  endproperty
  a_strap_gain: assert property (p_strap_gain) else $error("strap gain");
  property p_strap_en; s_strap ##0 !cable_detect_n |-> lane_enable == 4'hf; endproperty
  a_strap_en: assert property (p_strap_en) else $error("strap lane off");
  property p_regrst;
    s_regrst |-> lane_boost == 16'h0 && lane_flat_gain == 8'h0 && lane_out_level == 8'h0
      && lane_enable == 4'hf;
  endproperty
  a_regrst: assert property (p_regrst) else $error("register reset");
  // ====
  // Acknowledge drive timing on the data line
  property p_ack_fall; $rose(sda_oe) |-> !scl; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("sda drive in scl high");
  property p_oe_steady; scl && $past(scl) |-> $stable(sda_oe); endproperty
  a_oe_steady: assert property (p_oe_steady) else $error("sda moved in scl high");
endmodule : lcr_chk

bind lcr_top lcr_chk i_lcr_chk (
  .clock(clock), .arst_n(arst_n), .reg_reset_n(reg_reset_n), .cable_detect_n(cable_detect_n),
  .cfg_source_sel(cfg_source_sel), .boost_level_sel(boost_level_sel),
  .flat_gain_sel(flat_gain_sel), .output_level_sel(output_level_sel), .slave_id(slave_id),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .lane_boost(lane_boost),
  .lane_flat_gain(lane_flat_gain), .lane_out_level(lane_out_level),
  .lane_enable(lane_enable), .tx_hiz(tx_hiz), .rx_term_weak(rx_term_weak)
);

// file: bench/lcr_master.sv
// Serial bus master model: start, stop and nine-bit byte transfers.
// Assumes a pull-up on sda and one caller at a time.
`timescale 1ns/1ps
module lcr_master (
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  // ====
  // Idle bus, clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ====
  // Conditions; the odd offset keeps edges off the core clock
  task automatic start_c;
    #1.3;
    sda_low = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    sda_low = 1'b1;
    #40;
    scl = 1'b0;
  endtask : start_c
  // Data held past the scl fall before the line is pulled for the stop
  task automatic stop_c;
    #20;
    sda_low = 1'b1;
    #20;
    scl = 1'b1;
    #40;
    sda_low = 1'b0;
    #40;
  endtask : stop_c
  // One bit of an 80 ns clock, data set mid low, sampled mid high
  task automatic bit_c(input logic b, output logic r);
    #20;
    sda_low = !b;
    #20;
    scl = 1'b1;
    #20;
    r = sda;
    #20;
    scl = 1'b0;
  endtask : bit_c
  // Byte MSB first, then the ninth bit driven with mack
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_c(tx[i], rx[i]);
    bit_c(mack, ack);
  endtask : xfer
endmodule : lcr_master

// file: bench/testbench.sv
// Self-checking bench for the lane configuration core over its serial bus.
// Assumes lcr_top, lcr_master and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "lcr_map.svh"
module testbench;
  import lcr_pkg::*;
  localparam logic [3:0] ID = 4'h5; // Arbitrary slave id
  logic        clock, arst_n, reg_reset_n, cable_detect_n, cfg_source_sel;
  logic [3:0]  boost_level_sel, slave_id;
  logic [1:0]  flat_gain_sel, output_level_sel;
  logic        scl, m_low, sda_out, sda_oe, rx_term_weak;
  logic [15:0] lane_boost;
  logic [7:0]  lane_flat_gain, lane_out_level;
  logic [3:0]  lane_enable, tx_hiz;
  int          n_mismatch = 0;
  int          checks = 0;
  // Open-drain wire with pull-up
  wire sda = !(m_low || (sda_oe && !sda_out));
  lcr_top i_lcr_top (.clock(clock), .arst_n(arst_n), .reg_reset_n(reg_reset_n),
    .cable_detect_n(cable_detect_n), .cfg_source_sel(cfg_source_sel),
    .boost_level_sel(boost_level_sel), .flat_gain_sel(flat_gain_sel),
    .output_level_sel(output_level_sel), .slave_id(slave_id), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .lane_boost(lane_boost),
    .lane_flat_gain(lane_flat_gain), .lane_out_level(lane_out_level),
    .lane_enable(lane_enable), .tx_hiz(tx_hiz), .rx_term_weak(rx_term_weak));
  lcr_master i_lcr_master (.scl(scl), .sda_low(m_low), .sda(sda));
  // ====
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #300us;
    n_mismatch++;
    tally_and_finish();
  end
  // ====
  // Compare, verdict and bus tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic open_frame(input logic rd, input logic [3:0] id, output logic a);
    logic [7:0] rx;
    i_lcr_master.start_c();
    i_lcr_master.xfer({`LCR_ADDR_HI, id, rd}, 1'b1, rx, a);
  endtask : open_frame
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input int n);
    logic [7:0] rx;
    logic       a;
    open_frame(1'b0, ID, a);
    check(a, 16'h0);
    i_lcr_master.xfer(idx, 1'b1, rx, a);
    check(a, 16'h0);
    for (int i = 0; i < n; i++) begin
      i_lcr_master.xfer(d[31-8*i -: 8], 1'b1, rx, a);
      check(a, 16'h0);
    end
    i_lcr_master.stop_c();
    repeat (10) @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input int n);
    logic [7:0] rx;
    logic       a;
    wr(idx, 32'h0, 0);
    open_frame(1'b1, ID, a);
    check(a, 16'h0);
    for (int i = 0; i < n; i++) begin
      i_lcr_master.xfer(8'hff, i == n - 1, rx, a);
      check(rx, e[31-8*i -: 8]);
    end
    i_lcr_master.stop_c();
    repeat (10) @(posedge clock);
  endtask : rd
  task automatic pins(input logic cab, input logic src);
    @(posedge clock);
    cable_detect_n <= cab;
    cfg_source_sel <= src;
    repeat (12) @(posedge clock);
  endtask : pins
  // ====
  // Main sequence
  initial begin
    logic a;
    arst_n = 1'b0;
    reg_reset_n = 1'b1;
    cable_detect_n = 1'b0;
    cfg_source_sel = 1'b1;
    boost_level_sel = 4'h0;
    flat_gain_sel = 2'h0;
    output_level_sel = 2'h0;
    slave_id = ID;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (20) @(posedge clock);
    rd(8'h00, 32'h0, 4);
    open_frame(1'b0, ~ID, a);
    check(a, 16'h1);
    i_lcr_master.stop_c();
    wr(8'h03, 32'hb65d0000, 2);
    rd(8'h03, 32'hb65d0000, 2);
    check(lane_boost[7:0], 16'h5b);
    check({lane_flat_gain[3:0], lane_out_level[3:0]}, 16'hd6);
    wr(8'h02, 32'ha5000000, 1);
    check(lane_enable, 16'h5);
    wr(8'h00, 32'h3c000000, 1);
    rd(8'h00, 32'h0000a5b6, 4);
    pins(1'b1, 1'b1);
    check({rx_term_weak, lane_enable, tx_hiz}, 16'h10f);
    pins(1'b0, 1'b0);
    for (int c = 0; c < 16; c++) begin
      @(posedge clock);
      boost_level_sel <= c[3:0];
      flat_gain_sel <= c[1:0];
      output_level_sel <= ~c[1:0];
      repeat (12) @(posedge clock);
      check(lane_boost, {4{c[3:0]}});
      check({lane_flat_gain, lane_out_level}, {{4{c[1:0]}}, {4{~c[1:0]}}});
      check(lane_enable, 16'hf);
    end
    pins(1'b1, 1'b0);
    check({rx_term_weak, lane_enable}, 16'h10);
    pins(1'b0, 1'b1);
    reg_reset_n <= 1'b0;
    repeat (20) @(posedge clock);
    reg_reset_n <= 1'b1;
    repeat (12) @(posedge clock);
    check(lane_enable, 16'hf);
    rd(8'h02, 32'h0, 3);
    tally_and_finish();
  end
endmodule : testbench
